/* logic/rcd_core.sv */
// 8-bit RISC core datapath with debug slave and quarter-rate clock out.
// Assumes an async-read program store and register file on core_clk.
//
// Local design decisions: the Avalon-MM register port and the placing of the registers.
`timescale 1ns/1ps
module rcd_core #(
    parameter int PC_W = rcd_pkg::PC_W_LARGE
) (
    // Clock and resets
    input logic core_clk,
    input logic reset_n,
    input logic master_reset_n,
    // Program fetch bus
    output logic [PC_W-1:0] prog_addr,
    input logic [11:0] prog_data,
    // Register file bus
    output rcd_pkg::rcd_dreq_t data_req,
    input logic [7:0] data_rdata,
    // Avalon-MM slave
    input logic [3:0] avs_address,
    input logic avs_read,
    input logic avs_write,
    input logic [3:0] avs_byteenable,
    input logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // Clock output
    output logic quarter_rate_out
);
    logic [1:0] phase_r, phase_nxt;
    logic [11:0] ir_r, ir_nxt;
    logic [PC_W-1:0] pc_r, pc_nxt, stk0_r, stk0_nxt, stk1_r, stk1_nxt;
    logic [7:0] w_r, w_nxt, stat_r, stat_nxt, fsr_r, fsr_nxt;
    rcd_pkg::rcd_dreq_t dreq_r, dreq_nxt;
    rcd_pkg::rcd_ctrl_t ctrl_r, ctrl_nxt;
    logic qout_r, qout_nxt, ack_r, ack_nxt;
    logic [31:0] rdata_r, rdata_nxt;
    logic cyc_en, flush, pcl_wr;
    logic [7:0] eaddr, fv, res, aop, bop, mask;
    logic cin, wr_f, wr_w, fop, upd_z, upd_c, upd_nb, c_n;
    logic skip, jump, ret, call, is_sub;
    logic [8:0] sum9, dsum9;
    logic [11:0] tgt12, pcl12;

    // Shared adder; nine bits keep the carry
    function automatic logic [8:0] add9(input logic [7:0] a,
                                        input logic [7:0] b,
                                        input logic ci);
        add9 = {1'b0, a} + {1'b0, b} + {8'h00, ci};
    endfunction : add9

    // Locations served inside the core rather than on the file bus
    function automatic logic is_int(input logic [7:0] a);
        is_int = (a[4:0] == rcd_pkg::LOC_INDIRECT) ||
                 (a[4:0] == rcd_pkg::LOC_PCL) ||
                 (a[4:0] == rcd_pkg::LOC_STATUS) ||
                 (a[4:0] == rcd_pkg::LOC_FSR);
    endfunction : is_int

    // ----------------------------------------
    // Operand fetch
    // ----------------------------------------
    // Indirect through the pointer, or direct within its bank
    assign eaddr = (ir_r[4:0] == rcd_pkg::LOC_INDIRECT) ? fsr_r
                 : {fsr_r[7:5], ir_r[4:0]};
    assign cyc_en = ctrl_r.run && (phase_r == rcd_pkg::PHASE_LAST);

    // Counter, status and pointer read as file locations
    always_comb
    begin
        case (eaddr[4:0])
            rcd_pkg::LOC_INDIRECT: fv = 8'h00;
            rcd_pkg::LOC_PCL: fv = pc_r[7:0];
            rcd_pkg::LOC_STATUS: fv = stat_r;
            rcd_pkg::LOC_FSR: fv = fsr_r;
            default: fv = data_rdata;
        endcase
    end

    // Adder operands; subtraction adds the inverse plus one
    always_comb
    begin
        aop = fv;
        bop = w_r;
        cin = 1'b0;
        casez (ir_r[11:6])
            6'b000010: begin bop = ~w_r; cin = 1'b1; end
            6'b000011, 6'b001011: bop = 8'hFF;
            6'b001010, 6'b001111: begin bop = 8'h00; cin = 1'b1; end
            default: bop = w_r;
        endcase
        sum9 = add9(aop, bop, cin);
        dsum9 = add9({4'h0, aop[3:0]}, {4'h0, bop[3:0]}, cin);
    end

    // ----------------------------------------
    // Instruction decode and ALU
    // ----------------------------------------
    // Result defaults to the file value; the accumulator feeds only some ops
    always_comb
    begin
        res = fv;
        fop = 1'b0;
        wr_f = 1'b0;
        wr_w = 1'b0;
        upd_z = 1'b0;
        upd_c = 1'b0;
        upd_nb = 1'b0;
        c_n = sum9[8];
        skip = 1'b0;
        jump = 1'b0;
        ret = 1'b0;
        call = 1'b0;
        is_sub = 1'b0;
        mask = 8'h01 << ir_r[7:5];
        tgt12 = {1'b0, stat_r[6:5], ir_r[8:0]};
        casez (ir_r[11:5])
            7'b0000001: begin res = w_r; wr_f = 1'b1; end
            7'b000001?: begin res = 8'h00; fop = 1'b1; upd_z = 1'b1; end
            7'b000010?: begin
                res = sum9[7:0];
                fop = 1'b1;
                {upd_z, upd_c, upd_nb, is_sub} = 4'hF;
            end
            7'b000011?: begin res = sum9[7:0]; fop = 1'b1; upd_z = 1'b1; end
            7'b000100?: begin res = fv | w_r; fop = 1'b1; upd_z = 1'b1; end
            7'b000101?: begin res = fv & w_r; fop = 1'b1; upd_z = 1'b1; end
            7'b000110?: begin res = fv ^ w_r; fop = 1'b1; upd_z = 1'b1; end
            7'b000111?: begin
                res = sum9[7:0];
                fop = 1'b1;
                {upd_z, upd_c, upd_nb} = 3'h7;
            end
            7'b001000?: begin fop = 1'b1; upd_z = 1'b1; end
            7'b001001?: begin res = ~fv; fop = 1'b1; upd_z = 1'b1; end
            7'b001010?: begin res = sum9[7:0]; fop = 1'b1; upd_z = 1'b1; end
            7'b001011?, 7'b001111?: begin
                res = sum9[7:0];
                fop = 1'b1;
                skip = (sum9[7:0] == 8'h00);
            end
            7'b001100?: begin // Rotate right through carry
                res = {stat_r[rcd_pkg::ST_C], fv[7:1]};
                c_n = fv[0];
                fop = 1'b1;
                upd_c = 1'b1;
            end
            7'b001101?: begin
                res = {fv[6:0], stat_r[rcd_pkg::ST_C]};
                c_n = fv[7];
                fop = 1'b1;
                upd_c = 1'b1;
            end
            7'b001110?: begin res = {fv[3:0], fv[7:4]}; fop = 1'b1; end
            7'b0100???: begin res = fv & ~mask; wr_f = 1'b1; end
            7'b0101???: begin res = fv | mask; wr_f = 1'b1; end
            7'b0110???: skip = ((fv & mask) == 8'h00);
            7'b0111???: skip = ((fv & mask) != 8'h00);
            7'b1000???: begin
                res = ir_r[7:0];
                wr_w = 1'b1;
                jump = 1'b1;
                ret = 1'b1;
            end
            7'b1001???: begin
                tgt12 = {1'b0, stat_r[6:5], 1'b0, ir_r[7:0]};
                jump = 1'b1;
                call = 1'b1;
            end
            7'b101????: jump = 1'b1;
            7'b1100???: begin res = ir_r[7:0]; wr_w = 1'b1; end
            7'b1101???:
            begin
                res = ir_r[7:0] | w_r;
                wr_w = 1'b1;
                upd_z = 1'b1;
            end
            7'b1110???:
            begin
                res = ir_r[7:0] & w_r;
                wr_w = 1'b1;
                upd_z = 1'b1;
            end
            7'b1111???:
            begin
                res = ir_r[7:0] ^ w_r;
                wr_w = 1'b1;
                upd_z = 1'b1;
            end
            default: res = fv; // Control words run as no-ops
        endcase
        if (fop)
        begin
            wr_f = ir_r[5];
            wr_w = ~ir_r[5];
        end
    end

    // ----------------------------------------
    // Sequencer
    // ----------------------------------------
    // Four phases per cycle; state commits on the last phase only
    always_comb
    begin
        phase_nxt = phase_r;
        ir_nxt = ir_r;
        pc_nxt = pc_r;
        stk0_nxt = stk0_r;
        stk1_nxt = stk1_r;
        w_nxt = w_r;
        stat_nxt = stat_r;
        fsr_nxt = fsr_r;
        dreq_nxt = dreq_r;
        dreq_nxt.we = 1'b0;
        pcl12 = {1'b0, stat_r[6:5], 1'b0, res};
        pcl_wr = wr_f && (eaddr[4:0] == rcd_pkg::LOC_PCL);
        flush = jump || skip || pcl_wr;
        if (ctrl_r.run)
        begin
            phase_nxt = phase_r + 2'h1;
            if (phase_r == 2'h0)
                dreq_nxt.addr = eaddr;
            if (phase_r == 2'h2)
            begin
                // Internal locations never get a write strobe on the file bus
                dreq_nxt.wdata = res;
                dreq_nxt.we = wr_f && !is_int(eaddr);
            end
            if (cyc_en)
            begin
                // Fetched word dropped when flow changes
                ir_nxt = flush ? rcd_pkg::INSN_NOP : prog_data;
                pc_nxt = pc_r + {{(PC_W-1){1'b0}}, 1'b1};
                if (wr_w)
                    w_nxt = res;
                if (wr_f && eaddr[4:0] == rcd_pkg::LOC_STATUS)
                    stat_nxt = {res[7:5], stat_r[4:3], res[2:0]};
                if (wr_f && eaddr[4:0] == rcd_pkg::LOC_FSR)
                    fsr_nxt = res;
                if (pcl_wr)
                    pc_nxt = pcl12[PC_W-1:0];
                if (upd_z)
                    stat_nxt[rcd_pkg::ST_Z] = (res == 8'h00);
                if (upd_c)
                    stat_nxt[rcd_pkg::ST_C] = c_n;
                if (upd_nb)
                    stat_nxt[rcd_pkg::ST_NB] = dsum9[4];
                if (jump)
                    pc_nxt = ret ? stk0_r : tgt12[PC_W-1:0];
                if (call)
                begin
                    stk1_nxt = stk0_r;
                    stk0_nxt = pc_r;
                end
                if (ret)
                    stk0_nxt = stk1_r;
            end
        end
        // Pin reset is synchronous; bus registers survive it
        if (!master_reset_n)
        begin
            phase_nxt = 2'h0;
            ir_nxt = rcd_pkg::INSN_NOP;
            pc_nxt = '1;
            stat_nxt = rcd_pkg::STAT_RST;
            fsr_nxt = rcd_pkg::FSR_RST;
            dreq_nxt = '0;
        end
        // Output only on the last two phases, so a quarter of core_clk
        qout_nxt = ctrl_r.qen && phase_nxt[1];
    end

    // Core state registers
    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            phase_r <= 2'h0;
            ir_r <= rcd_pkg::INSN_NOP;
            pc_r <= '1;
            stk0_r <= '0;
            stk1_r <= '0;
            w_r <= rcd_pkg::W_RST;
            stat_r <= rcd_pkg::STAT_RST;
            fsr_r <= rcd_pkg::FSR_RST;
            dreq_r <= '0;
            qout_r <= 1'b0;
        end
        else
        begin
            phase_r <= phase_nxt;
            ir_r <= ir_nxt;
            pc_r <= pc_nxt;
            stk0_r <= stk0_nxt;
            stk1_r <= stk1_nxt;
            w_r <= w_nxt;
            stat_r <= stat_nxt;
            fsr_r <= fsr_nxt;
            dreq_r <= dreq_nxt;
            qout_r <= qout_nxt;
        end
    end

    assign prog_addr = pc_r;
    assign data_req = dreq_r;
    assign quarter_rate_out = qout_r;

    // ----------------------------------------
    // Avalon-MM slave
    // ----------------------------------------
    // One wait cycle; read data captured while the request waits
    always_comb
    begin
        ack_nxt = (avs_read || avs_write) && !ack_r;
        ctrl_nxt = ctrl_r;
        rdata_nxt = rdata_r;
        if (avs_read && !ack_r)
        begin
            case (avs_address)
                rcd_pkg::OFS_CTRL: rdata_nxt = {30'h0, ctrl_r};
                rcd_pkg::OFS_CORE: rdata_nxt = {8'h00, fsr_r, stat_r, w_r};
                rcd_pkg::OFS_FETCH: rdata_nxt = {4'h0, ir_r, 16'(pc_r)};
                default: rdata_nxt = 32'h0000_0000;
            endcase
        end
        if (avs_write && ack_r && avs_byteenable[0] &&
            avs_address == rcd_pkg::OFS_CTRL)
            ctrl_nxt = avs_writedata[1:0];
    end

    // Bus registers
    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            ctrl_r <= rcd_pkg::CTRL_RST;
            ack_r <= 1'b0;
            rdata_r <= 32'h0000_0000;
        end
        else
        begin
            ctrl_r <= ctrl_nxt;
            ack_r <= ack_nxt;
            rdata_r <= rdata_nxt;
        end
    end

    assign avs_waitrequest = (avs_read || avs_write) && !ack_r;
    assign avs_readdata = rdata_r;

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!reset_n);

    sequence s_q_high;
        quarter_rate_out [*2];
    endsequence
    sequence s_q_low;
        !quarter_rate_out [*2];
    endsequence

    a_phase_wrap: assert property (cyc_en && master_reset_n |=>
        phase_r == 2'h0) else $error("phase did not wrap");
    a_branch_flush: assert property (cyc_en && flush && master_reset_n
        |=> (ir_r == rcd_pkg::INSN_NOP) [*4]) else $error("no flush");
    a_fetch_take: assert property (cyc_en && !flush && master_reset_n
        |=> ir_r == $past(prog_data)) else $error("fetch lost");
    a_pc_step: assert property (cyc_en && !flush && master_reset_n
        |=> pc_r == PC_W'($past(pc_r) + 1'b1)) else $error("pc step");
    a_dual_bus: assert property (data_req.we |->
        phase_r == rcd_pkg::PHASE_LAST && data_req.addr == eaddr)
        else $error("file write misplaced");
    a_sub_borrow: assert property (cyc_en && is_sub && master_reset_n
        |=> stat_r[0] == ($past(fv) >= $past(w_r)) &&
            stat_r[1] == ($past(fv[3:0]) >= $past(w_r[3:0])))
        else $error("borrow flags wrong");
    a_zero_flag: assert property (cyc_en && upd_z && master_reset_n
        |=> stat_r[2] == ($past(res) == 8'h00)) else $error("zero flag");
    a_w_hidden: assert property (cyc_en && !wr_w && master_reset_n
        |=> w_r == $past(w_r)) else $error("accumulator changed");
    a_bus_answer: assert property ((avs_read || avs_write) &&
        avs_waitrequest |=> !avs_waitrequest) else $error("bus stalled");
    // A control write landing mid-window may legally stop the pin early
    a_quarter_rate: assert property (ctrl_r.run && ctrl_r.qen &&
        phase_r == 2'h1 && master_reset_n && !avs_write
        |=> s_q_high ##1 s_q_low) else $error("clock out rate");
endmodule : rcd_core

/* logic/rcd_pkg.sv */
// Constants and carriers for the 8-bit RISC core datapath.
// Assumes one 50 MHz clock domain and an Avalon-MM host for debug.
package rcd_pkg;
    // ----------------------------------------
    // Sizes
    // ----------------------------------------
    localparam int DATA_W = 8;
    localparam int INSN_W = 12;
    localparam int PC_W_LARGE = 11; // 2048-word program store
    localparam int PC_W_SMALL = 9;  // 512-word program store
    localparam int INSN_COUNT = 33;
    localparam logic [1:0] PHASE_LAST = 2'h3;

    // ----------------------------------------
    // Reset values
    // ----------------------------------------
    localparam logic [11:0] INSN_NOP = 12'h000;
    localparam logic [7:0] STAT_RST = 8'h18;
    localparam logic [7:0] W_RST = 8'h00;
    localparam logic [7:0] FSR_RST = 8'h00;
    localparam logic [1:0] CTRL_RST = 2'h1; // Running, clock out off

    // ----------------------------------------
    // Internal file locations (low five bits)
    // ----------------------------------------
    localparam logic [4:0] LOC_INDIRECT = 5'h00;
    localparam logic [4:0] LOC_PCL = 5'h02;
    localparam logic [4:0] LOC_STATUS = 5'h03;
    localparam logic [4:0] LOC_FSR = 5'h04;

    // Status bit positions
    localparam int ST_C = 0;
    localparam int ST_NB = 1;
    localparam int ST_Z = 2;

    // ----------------------------------------
    // Debug register byte offsets
    // ----------------------------------------
    localparam logic [3:0] OFS_CTRL = 4'h0;
    localparam logic [3:0] OFS_CORE = 4'h4;
    localparam logic [3:0] OFS_FETCH = 4'h8;

    typedef struct packed {
        logic qen;
        logic run;
    } rcd_ctrl_t;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic we;
    } rcd_dreq_t;
endpackage : rcd_pkg

/* tb/rcd_mem_model.sv */
// Program store and register file facing the core datapath.
// Assumes the same core_clk as rcd_core; the bench loads rom directly.
`timescale 1ns/1ps
module rcd_mem_model #(
    parameter int AW = 11
) (
    // Clock
    input logic core_clk,
    // Program bus
    input logic [AW-1:0] prog_addr,
    output logic [11:0] prog_data,
    // Register file bus
    input rcd_pkg::rcd_dreq_t data_req,
    output logic [7:0] data_rdata
);
    // ----------------------------------------
    // Storage
    // ----------------------------------------
    logic [11:0] rom [0:(1<<AW)-1];
    logic [7:0] ram [0:255];

    // Cleared so a stray fetch runs as a no-operation
    initial
    begin
        for (int i = 0; i < (1 << AW); i++)
            rom[i] = rcd_pkg::INSN_NOP;
        for (int i = 0; i < 256; i++)
            ram[i] = 8'h00;
    end

    // Whole word per fetch, on a bus of its own
    assign prog_data = rom[prog_addr];
    assign data_rdata = ram[data_req.addr];

    // Write lands on the edge that ends the pulse
    always @(posedge core_clk)
    begin
        if (data_req.we === 1'b1)
            ram[data_req.addr] <= data_req.wdata;
    end
endmodule : rcd_mem_model

/* tb/risc_core_datapath_tb.sv */
// Self-checking bench for rcd_core: debug bus, ALU programs, clock out.
// Assumes rcd_mem_model as program store and file; one 50 MHz clock.
`timescale 1ns/1ps
module risc_core_datapath_tb;
    // ----------------------------------------
    // Signals
    // ----------------------------------------
    logic core_clk;
    logic reset_n;
    logic master_reset_n;
    logic [10:0] prog_addr;
    logic [11:0] prog_data;
    rcd_pkg::rcd_dreq_t data_req;
    logic [7:0] data_rdata;
    logic [3:0] avs_address;
    logic avs_read;
    logic avs_write;
    logic [3:0] avs_byteenable;
    logic [31:0] avs_writedata;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic quarter_rate_out;
    int miscompares = 0;
    int compares = 0;
    logic [31:0] expq [$];
    // Second operand opcodes on file 0x10, result to W
    logic [11:0] ops [6] = '{12'h1D0, 12'h090, 12'h150, 12'h110,
                            12'h190, 12'h310};

    rcd_core #(.PC_W(rcd_pkg::PC_W_LARGE)) i_rcd_core (
        .core_clk(core_clk), .reset_n(reset_n),
        .master_reset_n(master_reset_n),
        .prog_addr(prog_addr), .prog_data(prog_data),
        .data_req(data_req), .data_rdata(data_rdata),
        .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_byteenable(avs_byteenable),
        .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest),
        .quarter_rate_out(quarter_rate_out));

    rcd_mem_model #(.AW(11)) i_rcd_mem_model (
        .core_clk(core_clk), .prog_addr(prog_addr), .prog_data(prog_data),
        .data_req(data_req), .data_rdata(data_rdata));

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    task automatic tally_and_finish;
        $display("compares=%0d miscompares=%0d", compares, miscompares);
        if (miscompares == 0 && compares > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : tally_and_finish

    // Reference result {z, nb, c, w}; carry means no borrow on subtract
    function automatic logic [10:0] alu_ref(input int op,
        input logic [7:0] f, input logic [7:0] w);
        logic [8:0] r;
        logic c;
        logic nb;
        c = 1'b0;
        nb = 1'b0;
        case (op)
            0:
            begin
                r = {1'b0, f} + {1'b0, w};
                c = r[8];
                nb = ({1'b0, f[3:0]} + {1'b0, w[3:0]}) > 5'h0F;
            end
            1:
            begin
                r = {1'b0, f} - {1'b0, w};
                c = f >= w;
                nb = f[3:0] >= w[3:0];
            end
            2: r = {1'b0, f & w};
            3: r = {1'b0, f | w};
            4: r = {1'b0, f ^ w};
            default:
            begin
                r = {2'b00, f[7:1]};
                c = f[0];
            end
        endcase
        return {(op != 5) && (r[7:0] == 8'h00), nb, c, r[7:0]};
    endfunction : alu_ref

    // One Avalon transfer, held until waitrequest is seen low
    task automatic bus(input logic wr, input logic [3:0] adr,
        input logic [31:0] wd, input logic [3:0] be, input logic [31:0] exp);
        @(posedge core_clk);
        avs_read <= ~wr;
        avs_write <= wr;
        avs_address <= adr;
        avs_writedata <= wd;
        avs_byteenable <= be;
        if (!wr)
            expq.push_back(exp);
        @(posedge core_clk);
        while (avs_waitrequest !== 1'b0)
            @(posedge core_clk);
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask : bus

    // Bounded wait for a fetch address
    task automatic wait_pc(input logic [10:0] a);
        int n;
        n = 0;
        while (prog_addr !== a && n < 200)
        begin
            n++;
            @(posedge core_clk);
        end
        check({21'h0, prog_addr}, {21'h0, a});
    endtask : wait_pc

    // Read data taken at the accepting edge, oldest note first
    always @(posedge core_clk)
    begin
        if (avs_read === 1'b1 && avs_waitrequest === 1'b0)
            check(avs_readdata, expq.pop_front());
    end

    initial
    begin
        core_clk = 1'b0;
        forever
            #10 core_clk = ~core_clk;
    end

    // Watchdog sized well past the whole sequence
    initial
    begin
        repeat (20000) @(posedge core_clk);
        miscompares++;
        tally_and_finish();
    end

    // ----------------------------------------
    // Sequence
    // ----------------------------------------
    initial
    begin
        int n;
        logic [7:0] a;
        logic [7:0] b;
        logic [10:0] r;
        logic [10:0] pc_hold;
        logic prev;
        reset_n = 1'b0;
        master_reset_n = 1'b0;
        {avs_read, avs_write, avs_address} = 6'h00;
        avs_byteenable = 4'h0;
        avs_writedata = 32'h0;
        void'($urandom(32'h8790668c));
        repeat (2) @(posedge core_clk);
        reset_n <= 1'b1;
        bus(1'b0, rcd_pkg::OFS_CTRL, 32'h0, 4'h0, 32'h1);
        bus(1'b0, rcd_pkg::OFS_CORE, 32'h0, 4'h0, 32'h1800);
        bus(1'b0, rcd_pkg::OFS_FETCH, 32'h0, 4'h0, 32'h7FF);
        bus(1'b0, 4'hC, 32'h0, 4'h0, 32'h0);
        bus(1'b1, rcd_pkg::OFS_CTRL, 32'h0, 4'hE, 32'h0);
        bus(1'b0, rcd_pkg::OFS_CTRL, 32'h0, 4'h0, 32'h1);
        $display("test reset_values done");
        // Each op twice; trial 6 adds to zero, trial 7 subtracts to zero
        for (int t = 0; t < 12; t++)
        begin
            a = 8'($urandom());
            b = (t == 6) ? -a : (t == 7) ? a : 8'($urandom());
            r = alu_ref(t % 6, a, b);
            @(posedge core_clk);
            master_reset_n <= 1'b0;
            i_rcd_mem_model.rom[11'h7FF] = 12'hA00;
            i_rcd_mem_model.rom[0] = {4'hC, a};
            i_rcd_mem_model.rom[1] = 12'h030;
            i_rcd_mem_model.rom[2] = {4'hC, b};
            i_rcd_mem_model.rom[3] = ops[t % 6];
            i_rcd_mem_model.rom[4] = 12'hA04;
            repeat (2) @(posedge core_clk);
            master_reset_n <= 1'b1;
            wait_pc(11'h001);
            n = 0;
            while (prog_addr === 11'h001 && n < 20)
            begin
                n++;
                @(posedge core_clk);
            end
            check(32'(n), 32'd4);
            wait_pc(11'h004);
            repeat (8) @(posedge core_clk);
            bus(1'b0, rcd_pkg::OFS_CORE, 32'h0, 4'h0,
                {16'h0, 5'h03, r});
            check({24'h0, i_rcd_mem_model.ram[8'h10]}, {24'h0, a});
        end
        $display("test alu_ops done");
        // Branch loop alternates 4 and 5, four clocks each
        n = 0;
        repeat (32)
        begin
            @(posedge core_clk);
            if (prog_addr === 11'h004)
                n++;
        end
        check(32'(n), 32'd16);
        $display("test branch_loop done");
        bus(1'b1, rcd_pkg::OFS_CTRL, 32'h3, 4'h1, 32'h0);
        repeat (8) @(posedge core_clk);
        n = 0;
        prev = quarter_rate_out;
        repeat (16)
        begin
            @(posedge core_clk);
            if (quarter_rate_out === 1'b1 && prev === 1'b0)
                n++;
            prev = quarter_rate_out;
        end
        check(32'(n), 32'd4);
        // Halted with output off: fetch address and pin must freeze
        bus(1'b1, rcd_pkg::OFS_CTRL, 32'h0, 4'h1, 32'h0);
        repeat (8) @(posedge core_clk);
        pc_hold = prog_addr;
        repeat (12) @(posedge core_clk);
        check({20'h0, quarter_rate_out, prog_addr},
            {20'h0, 1'b0, pc_hold});
        bus(1'b0, rcd_pkg::OFS_CTRL, 32'h0, 4'h0, 32'h0);
        $display("test clock_out done");
        tally_and_finish();
    end
endmodule : risc_core_datapath_tb
